// [design/urd_map.vh]
// register map, field positions, reset values and counts of the receive data recovery block
`ifndef URD_MAP_VH
`define URD_MAP_VH
`define URD_ADR_CTRL1 8'h00
`define URD_ADR_CTRL2 8'h04
`define URD_ADR_STAT1 8'h08
`define URD_ADR_DATA 8'h0C
`define URD_ADR_BAUD 8'h10
`define URD_C1_LEN 4
`define URD_C1_WAKE 3
`define URD_C1_IDLESEL 2
`define URD_C2_RXIE 5
`define URD_C2_ILIE 4
`define URD_C2_RXEN 2
`define URD_C2_STBY 1
`define URD_S1_FULL 5
`define URD_S1_IDLE 4
`define URD_S1_NOISE 2
`define URD_S1_FRAME 1
`define URD_RST_CTRL 8'h00
`define URD_C1_MASK 8'h1C
`define URD_C2_MASK 8'h36
`define URD_RST_BAUD 16'h0000
`define URD_OVS 4'hF
`define URD_RT3 4'h2
`define URD_RT5 4'h4
`define URD_RT7 4'h6
`define URD_RT8 4'h7
`define URD_RT9 4'h8
`define URD_RT10 4'h9
`define URD_EARLY_MIN 4'hA
`define URD_LATE_MAX 4'h6
`define URD_IDLE8 8'hA0
`define URD_IDLE9 8'hB0
`endif

// [design/urd_rx.v]
// receive data recovery with oversampled start, data and stop decisions and a wishbone slave
// How it works
// R01 - shift serial bits in, host sees read-only buffer
// R02 - full character copies data, sets full flag
// R03 - interrupt when full flag and enable set
// R04 - sample input on sixteen-times oversample tick
// R05 - realign after start and one-to-zero bit change
// R06 - hunt low after three highs, start count
// R07 - verify start at ticks 3,5,7; noise
// R08 - failed verification restarts the hunt
// R09 - data bit majority of ticks 8,9,10; noise
// R10 - late high start samples only set noise
// R11 - stop majority low gives framing, disagree noise
// R12 - framing error set together with full flag
// R13 - slow stop starting at tick 8 passes
// R14 - fast stop ending at tick 10 passes
// R15 - standby suppresses receiver interrupts until wakeup
// R16 - address mark clears standby, sets full
// R17 - waking idle sets neither idle nor full
// R18 - idle count starts after start or stop
// R19 - standby during idle line may wake immediately
// R20 - length select; ninth bit or copy of bit 7
// R21 - idle flag after 10 or 11 high bits
// R22 - two-stage synchroniser before any sampling logic
// R23 - count wraps at sixteen, bit count continues
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "urd_map.vh"
module urd_rx (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// serial line and request
	input wire rx_i,
	output wire rx_irq_o
);
	localparam [3:0] ST_HUNT = 4'h1;
	localparam [3:0] ST_START = 4'h2;
	localparam [3:0] ST_DATA = 4'h4;
	localparam [3:0] ST_STOP = 4'h8;

	// majority of three samples
	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		end
	endfunction

	// three samples disagree
	function mixed3;
		input [2:0] s;
		begin
			mixed3 = (s != 3'h0) && (s != 3'h7);
		end
	endfunction

	// count of high samples among three
	function [1:0] ones3;
		input [2:0] s;
		begin
			ones3 = {1'b0, s[0]} + {1'b0, s[1]} + {1'b0, s[2]};
		end
	endfunction

	reg sync1_r;
	reg sync2_r;
	reg smp_prev_r;
	reg [2:0] hist_r;
	reg [15:0] div_cnt_r;
	reg tick_r;
	reg [3:0] state_r;
	reg [3:0] rt_r;
	reg [3:0] bitcnt_r;
	reg [2:0] smp_r;
	reg [8:0] shift_r;
	reg noise_acc_r;
	reg last_one_r;
	reg [7:0] idle_cnt_r;
	reg idle_done_r;
	reg [7:0] ctrl1_r;
	reg [7:0] ctrl2_r;
	reg [15:0] baud_r;
	reg [7:0] rx_data_buffer_r;
	reg ninth_rx_bit_r;
	reg rx_full_flag_r;
	reg idle_flag_r;
	reg noise_flag_r;
	reg framing_error_flag_r;
	reg ack_r;
	reg [31:0] dat_r;
	reg irq_r;
	reg [3:0] state_nxt;

	wire char_len = ctrl1_r[`URD_C1_LEN];
	wire wake_sel = ctrl1_r[`URD_C1_WAKE];
	wire idle_count_start_select = ctrl1_r[`URD_C1_IDLESEL];
	wire rx_full_irq_enable = ctrl2_r[`URD_C2_RXIE];
	wire idle_irq_enable = ctrl2_r[`URD_C2_ILIE];
	wire rx_enable = ctrl2_r[`URD_C2_RXEN];
	wire rx_standby = ctrl2_r[`URD_C2_STBY];

	wire req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr0 = req & wb_we_i & wb_sel_i[0];
	wire wr1 = req & wb_we_i & wb_sel_i[1];
	wire rd = req & ~wb_we_i;

	// the oversampled line; only the second synchroniser stage feeds it
	wire smp = sync2_r;
	wire fall = tick_r & smp_prev_r & ~smp;
	wire [2:0] smp_cur = {smp_r[2:1], smp};
	wire [3:0] last_bit = char_len ? 4'h8 : 4'h7;
	// a falling edge after a one bit, except at ticks 8 to 10, moves the bit boundary onto this tick
	wire in_bits = (state_r == ST_DATA) | (state_r == ST_STOP);
	wire edge_ok = in_bits & fall & last_one_r;
	wire early = edge_ok & (rt_r >= `URD_EARLY_MIN); // R05 R14
	wire late = edge_ok & (rt_r <= `URD_LATE_MAX); // R05 R13
	wire wrap = tick_r & ((rt_r == `URD_OVS) | early); // R23
	wire at_rt7 = tick_r & (rt_r == `URD_RT7);
	wire at_rt10 = tick_r & (rt_r == `URD_RT10);
	wire start_bad = ones3(smp_cur) > 2'd1; // R07
	wire fail = (state_r == ST_START) & at_rt7 & start_bad; // R08
	wire stop_done = (state_r == ST_STOP) & at_rt10;
	wire stop_one = maj3(smp_cur);
	wire [8:0] char_w = char_len ? shift_r : {1'b0, shift_r[8:1]};
	wire msb = char_len ? char_w[8] : char_w[7];
	wire deliver = stop_done & (~rx_standby | (wake_sel & msb)); // R16
	wire [7:0] idle_lim = char_len ? `URD_IDLE9 : `URD_IDLE8;
	wire idle_hit = idle_cnt_r == idle_lim; // R21
	wire idle_wake = idle_hit & rx_standby & ~wake_sel; // R17 R19
	wire idle_evt = idle_hit & ~idle_done_r & ~(rx_standby & ~wake_sel);
	wire rd_data = rd & (wb_adr_i == `URD_ADR_DATA);
	wire wr_stat = wr0 & (wb_adr_i == `URD_ADR_STAT1);

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= rx_i; // R22
			sync2_r <= sync1_r; // R22
		end
	end

	// tick every baud_r+1 clocks, sixteen per bit
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_r <= `URD_RST_BAUD;
			tick_r <= 1'b0;
		end else if (div_cnt_r == 16'h0000) begin
			div_cnt_r <= baud_r;
			tick_r <= 1'b1; // R04
		end else begin
			div_cnt_r <= div_cnt_r - 16'h0001;
			tick_r <= 1'b0;
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_HUNT: begin
				if (tick_r & rx_enable & (hist_r == 3'h7) & ~smp)
					state_nxt = ST_START; // R06
			end
			ST_START: begin
				if (fail)
					state_nxt = ST_HUNT; // R08
				else if (wrap)
					state_nxt = ST_DATA;
			end
			ST_DATA: begin
				if (wrap & (bitcnt_r == last_bit))
					state_nxt = ST_STOP; // R23
			end
			ST_STOP: begin
				if (stop_done)
					state_nxt = ST_HUNT;
			end
			default: state_nxt = ST_HUNT;
		endcase
		if (~rx_enable)
			state_nxt = ST_HUNT;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_HUNT;
			rt_r <= 4'h0;
			bitcnt_r <= 4'h0;
			smp_r <= 3'h0;
			shift_r <= 9'h000;
			noise_acc_r <= 1'b0;
			last_one_r <= 1'b0;
			hist_r <= 3'h0;
			smp_prev_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			if (tick_r) begin
				hist_r <= {hist_r[1:0], smp};
				smp_prev_r <= smp;
			end
			if (state_r == ST_HUNT) begin
				rt_r <= 4'h1; // R05
				bitcnt_r <= 4'h0;
				noise_acc_r <= 1'b0;
				last_one_r <= 1'b0;
			end else if (wrap | late) begin
				// a resync edge is itself tick 1, as the start edge is
				rt_r <= (early | late) ? 4'h1 : 4'h0; // R05
				if (wrap & (state_r == ST_DATA))
					bitcnt_r <= bitcnt_r + 4'h1; // R23
			end else if (tick_r) begin
				rt_r <= rt_r + 4'h1;
			end
			if (tick_r) begin
				if (rt_r == `URD_RT3 || rt_r == `URD_RT8)
					smp_r[2] <= smp;
				if (rt_r == `URD_RT5 || rt_r == `URD_RT9)
					smp_r[1] <= smp;
			end
			if ((state_r == ST_START) & at_rt7 & (ones3(smp_cur) == 2'd1))
				noise_acc_r <= 1'b1; // R07
			if ((state_r == ST_START) & at_rt10 & (smp_cur != 3'h0))
				noise_acc_r <= 1'b1; // R10
			if ((state_r == ST_DATA) & at_rt10) begin
				shift_r <= {maj3(smp_cur), shift_r[8:1]}; // R01 R09
				if (mixed3(smp_cur))
					noise_acc_r <= 1'b1; // R09
			end
			if (in_bits & at_rt10)
				last_one_r <= maj3(smp_cur);
		end
	end

	// idle counter runs on ticks with the line high
	always @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt_r <= 8'h00;
			idle_done_r <= 1'b0;
		end else if (~rx_enable | (tick_r & ~smp)) begin
			idle_cnt_r <= 8'h00;
			idle_done_r <= 1'b0;
		end else if (idle_count_start_select & ((state_r == ST_START) | (state_r == ST_DATA))) begin
			idle_cnt_r <= 8'h00; // R18
		end else begin
			if (tick_r & ~idle_hit)
				idle_cnt_r <= idle_cnt_r + 8'h01; // R18
			if (idle_hit)
				idle_done_r <= 1'b1;
		end
	end

	// flags: a hardware set in the same cycle as a clear wins
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_data_buffer_r <= 8'h00;
			ninth_rx_bit_r <= 1'b0;
			rx_full_flag_r <= 1'b0;
			idle_flag_r <= 1'b0;
			noise_flag_r <= 1'b0;
			framing_error_flag_r <= 1'b0;
		end else begin
			if (rd_data)
				rx_full_flag_r <= 1'b0;
			if (wr_stat & wb_dat_i[`URD_S1_IDLE])
				idle_flag_r <= 1'b0;
			if (wr_stat & wb_dat_i[`URD_S1_NOISE])
				noise_flag_r <= 1'b0;
			if (wr_stat & wb_dat_i[`URD_S1_FRAME])
				framing_error_flag_r <= 1'b0;
			if (deliver) begin
				rx_data_buffer_r <= char_w[7:0]; // R02
				ninth_rx_bit_r <= msb; // R20
				rx_full_flag_r <= 1'b1; // R02 R12
				if (~stop_one)
					framing_error_flag_r <= 1'b1; // R11 R12
				if (noise_acc_r | mixed3(smp_cur))
					noise_flag_r <= 1'b1; // R11
			end
			if (idle_evt)
				idle_flag_r <= 1'b1; // R21 R17
		end
	end

	// control registers, standby cleared by either wakeup
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl1_r <= `URD_RST_CTRL;
			ctrl2_r <= `URD_RST_CTRL;
			baud_r <= `URD_RST_BAUD;
		end else begin
			// unimplemented control bits always read zero
			if (wr0 & (wb_adr_i == `URD_ADR_CTRL1))
				ctrl1_r <= wb_dat_i[7:0] & `URD_C1_MASK;
			if (wr0 & (wb_adr_i == `URD_ADR_CTRL2))
				ctrl2_r <= wb_dat_i[7:0] & `URD_C2_MASK; // R15
			if (wr0 & (wb_adr_i == `URD_ADR_BAUD))
				baud_r[7:0] <= wb_dat_i[7:0];
			if (wr1 & (wb_adr_i == `URD_ADR_BAUD))
				baud_r[15:8] <= wb_dat_i[15:8];
			if ((stop_done & rx_standby & wake_sel & msb) | idle_wake)
				ctrl2_r[`URD_C2_STBY] <= 1'b0; // R16 R17
		end
	end

	// bus answer one cycle after the request, unmapped reads return zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
			irq_r <= 1'b0;
		end else begin
			ack_r <= req;
			irq_r <= ~rx_standby & ((rx_full_flag_r & rx_full_irq_enable) |
				(idle_flag_r & idle_irq_enable)); // R03 R15
			if (rd) begin
				case (wb_adr_i)
					`URD_ADR_CTRL1: dat_r <= {24'h000000, ctrl1_r};
					`URD_ADR_CTRL2: dat_r <= {24'h000000, ctrl2_r};
					`URD_ADR_STAT1: dat_r <= {26'h0000000, rx_full_flag_r, idle_flag_r,
						1'b0, noise_flag_r, framing_error_flag_r, 1'b0};
					`URD_ADR_DATA: dat_r <= {23'h000000, ninth_rx_bit_r, rx_data_buffer_r}; // R01
					`URD_ADR_BAUD: dat_r <= {16'h0000, baud_r};
					default: dat_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign rx_irq_o = irq_r;
endmodule // urd_rx

// [bench/urd_rx_checker.sv]
// assertions on the bus and request ports of the receiver
`timescale 1ns/1ps
module urd_rx_checker (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// bus and request
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire rx_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd(logic [7:0] a);
		s_req ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	property p_hole; s_rd(8'h14) |=> wb_dat_o == 32'h0; endproperty
	property p_data; s_rd(8'h0C) |=> wb_dat_o[31:9] == 23'h0; endproperty
	property p_stat; s_rd(8'h08) |=> (wb_dat_o & 32'hFFFFFFC9) == 32'h0; endproperty
	property p_ctl; s_rd(8'h04) |=> (wb_dat_o & 32'hFFFFFFC9) == 32'h0; endproperty
	// the request only drops through a host access
	property p_fall;
		$fell(rx_irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
	endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");
	a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
	a_cause: assert property (p_cause) else $error("ack without request");
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	a_data: assert property (p_data) else $error("buffer upper bits set");
	a_stat: assert property (p_stat) else $error("status stray bits");
	a_ctl: assert property (p_ctl) else $error("control stray bits");
	a_fall: assert property (p_fall) else $error("request dropped alone");
endmodule // urd_rx_checker
bind urd_rx urd_rx_checker urd_rx_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_irq_o(rx_irq_o));

// [bench/urd_tx_model.sv]
// serial transmitter at the far end of the receive line
`timescale 1ns/1ps
module urd_tx_model (
	input wire clk_i,
	output logic rx_o
);
	initial rx_o = 1'b1;
	// per is clocks per bit; gl flips one tick of the first data bit
	task automatic send(input logic [8:0] d, input int nb, input int per,
		input logic stp, input int gl);
		logic [10:0] f;
		int i;
		int c;
		f = 11'h7FF;
		f[0] = 1'b0;
		for (i = 0; i < nb; i++) f[i + 1] = d[i];
		f[nb + 1] = stp;
		for (i = 0; i <= nb + 1; i++) begin
			for (c = 0; c < per; c++) begin
				@(posedge clk_i);
				rx_o <= f[i] ^ (i == 1 && gl > 0 && c >= gl && c < gl + 2);
			end
		end
		@(posedge clk_i);
		rx_o <= 1'b1;
	endtask
	task automatic pulse(input int n);
		@(posedge clk_i);
		rx_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		rx_o <= 1'b1;
	endtask
endmodule // urd_tx_model

// [bench/urd_rx_tb.sv]
// self-checking bench for the receive data recovery block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module urd_rx_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o;
	wire rx_i;
	wire rx_irq_o;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int k;
	logic [31:0] seed = 32'hA629FD8C;
	logic [8:0] d;
	logic nine;
	urd_rx urd_rx_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i),
		.rx_irq_o(rx_irq_o));
	urd_tx_model urd_tx_model_inst (.clk_i(clk_i), .rx_o(rx_i));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] exp_data(input logic [8:0] v, input logic n9);
		return {23'h0, n9 ? v[8] : v[7], v[7:0]};
	endfunction
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// hang guard, well above the length of the whole sequence
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			results();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= v;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] q;
		bus(1'b1, a, v, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	task automatic ch(input logic [8:0] v, input int nb, input int per, input logic stp,
		input int gl, input logic [31:0] st);
		wr(8'h08, 32'h16);
		urd_tx_model_inst.send(v, nb, per, stp, gl);
		while (rx_irq_o !== 1'b1) @(posedge clk_i);
		rd_chk(8'h08, st);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h08, 32'h0);
		rd_chk(8'h14, 32'h0);
		$display("reset values done");
		wr(8'h10, 32'h1);
		wr(8'h04, 32'h24);
		for (k = 0; k < 6; k++) begin
			seed = xs(seed);
			d = seed[8:0];
			nine = seed[9];
			wr(8'h00, {27'h0, nine, 4'h4});
			ch(d, nine ? 9 : 8, 32, 1'b1, 0, 32'h20);
			rd_chk(8'h0C, exp_data(d, nine));
			repeat (2) @(posedge clk_i);
			`CHK(rx_irq_o, 1'b0)
		end
		$display("random characters done");
		wr(8'h00, 32'h04);
		ch(9'h000, 8, 32, 1'b0, 0, 32'h22);
		rd_chk(8'h0C, 32'h0);
		ch(9'h05A, 8, 32, 1'b1, 16, 32'h24);
		rd_chk(8'h0C, 32'h5A);
		ch(9'h0A5, 8, 33, 1'b1, 0, 32'h20);
		rd_chk(8'h0C, 32'h1A5);
		ch(9'h03C, 8, 31, 1'b1, 0, 32'h20);
		rd_chk(8'h0C, 32'h3C);
		wr(8'h08, 32'h16);
		urd_tx_model_inst.pulse(2);
		repeat (400) @(posedge clk_i);
		rd_chk(8'h08, 32'h10);
		// count after start: an all-ones character runs into the idle threshold soon after stop
		wr(8'h00, 32'h00);
		ch(9'h0FF, 8, 32, 1'b1, 0, 32'h20);
		rd_chk(8'h0C, exp_data(9'h0FF, 1'b0));
		repeat (60) @(posedge clk_i);
		rd_chk(8'h08, 32'h10);
		$display("sampling corners done");
		wr(8'h00, 32'h0C);
		// stray bits on top of standby, enable and full interrupt must not stick
		wr(8'h04, 32'hEF);
		wr(8'h08, 32'h16);
		urd_tx_model_inst.send(9'h012, 8, 32, 1'b1, 0);
		repeat (4) @(posedge clk_i);
		`CHK(rx_irq_o, 1'b0)
		rd_chk(8'h08, 32'h0);
		ch(9'h092, 8, 32, 1'b1, 0, 32'h20);
		rd_chk(8'h04, 32'h24);
		rd_chk(8'h0C, 32'h192);
		wr(8'h00, 32'h04);
		repeat (400) @(posedge clk_i);
		wr(8'h04, 32'h26);
		repeat (4) @(posedge clk_i);
		rd_chk(8'h04, 32'h24);
		$display("standby wakeup done");
		results();
	end
endmodule // urd_rx_tb
